// File: dpx_exception_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dpx_exception_unit (
  // Clock, reset and enable.
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic              CLK_EN,
  // Issue from the decoder.
  input  wire dpx_pkg::issue_t   ISSUE,
  // Control fields of the control/status register.
  input  wire logic [1:0]        ROUND_FIELD,
  input  wire dpx_pkg::fp_flags_t EXC_MASK,
  input  wire logic              STICKY_CLEAR,
  // Arithmetic datapath, serving the operation in stage one.
  output var  dpx_pkg::issue_t   STAGE,
  output logic [1:0]             ROUND_SEL,
  input  wire logic [127:0]      ARITH_RESULT,
  input  wire dpx_pkg::fp_flags_t ARITH_COND,
  // Results.
  output logic                   RESULT_VALID,
  output logic [127:0]           RESULT,
  output logic [31:0]            GPR_RESULT,
  output var  dpx_pkg::int_flags_t INT_FLAGS,
  output logic                   INT_FLAGS_VALID,
  output var  dpx_pkg::fp_flags_t STICKY_FLAGS,
  output logic                   EXC_SIGNAL
);

  typedef struct packed {
    dpx_pkg::issue_t    s1;
    logic [1:0]         rsel;
    logic               out_valid;
    logic [127:0]       result;
    logic [31:0]        gpr;
    dpx_pkg::int_flags_t iflags;
    logic               iflags_valid;
    dpx_pkg::fp_flags_t sticky;
    logic               exc;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  function automatic logic is_nan(input logic [63:0] v);
    return (v[dpx_pkg::EXP_HI:dpx_pkg::EXP_LO] == dpx_pkg::EXP_ONES) && (v[dpx_pkg::EXP_LO-1:0] != '0);
  endfunction

  function automatic logic is_snan(input logic [63:0] v);
    return is_nan(v) && !v[dpx_pkg::QUIET_BIT];
  endfunction

  function automatic logic is_den(input logic [63:0] v);
    return (v[dpx_pkg::EXP_HI:dpx_pkg::EXP_LO] == '0) && (v[dpx_pkg::EXP_LO-1:0] != '0);
  endfunction

  // Returns {unordered, less, equal} for a against b.
  function automatic logic [2:0] fcmp(input logic [63:0] a, input logic [63:0] b);
    logic sa;
    logic sb;
    logic mag_lt;
    sa = a[dpx_pkg::DW-1];
    sb = b[dpx_pkg::DW-1];
    mag_lt = a[dpx_pkg::DW-2:0] < b[dpx_pkg::DW-2:0];
    if (is_nan(a) || is_nan(b)) begin
      return 3'h4;
    end else if ((a[dpx_pkg::DW-2:0] == '0) && (b[dpx_pkg::DW-2:0] == '0)) begin
      return 3'h1;
    end else if (sa != sb) begin
      return {1'b0, sa, 1'b0};
    end else if (a == b) begin
      return 3'h1;
    end else begin
      return {1'b0, mag_lt ^ sa, 1'b0};
    end
  endfunction

  // Which conditions each operation class may raise.
  function automatic dpx_pkg::fp_flags_t allowed(input dpx_pkg::op_t op);
    case (op)
      dpx_pkg::OP_ADD, dpx_pkg::OP_SUB:                 return dpx_pkg::MAP_ARITH;
      dpx_pkg::OP_MUL:                                  return dpx_pkg::MAP_ARITH;
      dpx_pkg::OP_DIV:                                  return dpx_pkg::MAP_DIV;
      dpx_pkg::OP_SQRT:                                 return dpx_pkg::MAP_SQRT;
      dpx_pkg::OP_CMP_PRED:                             return dpx_pkg::MAP_CMP;
      dpx_pkg::OP_CMP_ORD, dpx_pkg::OP_CMP_UNORD:       return dpx_pkg::MAP_CMP;
      dpx_pkg::OP_MAX, dpx_pkg::OP_MIN:                 return dpx_pkg::MAP_CMP;
      dpx_pkg::OP_I2S:                                  return dpx_pkg::MAP_I2S;
      dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC:     return dpx_pkg::MAP_F2I;
      dpx_pkg::OP_NARROW:                               return dpx_pkg::MAP_ARITH;
      dpx_pkg::OP_WIDEN:                                return dpx_pkg::MAP_CMP;
      default:                                          return dpx_pkg::MAP_NONE;
    endcase
  endfunction

  function automatic logic pred(input logic [2:0] c, input logic [2:0] p);
    case (p)
      dpx_pkg::PR_EQ:    return c[0];
      dpx_pkg::PR_LT:    return c[1];
      dpx_pkg::PR_LE:    return c[1] | c[0];
      dpx_pkg::PR_UNORD: return c[2];
      dpx_pkg::PR_NEQ:   return !c[0];
      dpx_pkg::PR_NLT:   return !c[1];
      dpx_pkg::PR_NLE:   return !(c[1] | c[0]);
      default:           return !c[2];
    endcase
  endfunction

  always_comb begin
    dpx_pkg::issue_t    s;
    dpx_pkg::fp_flags_t cond;
    dpx_pkg::fp_flags_t raised;
    logic [127:0]       res;
    logic [2:0]         c;
    logic [63:0]        ea;
    logic [63:0]        eb;
    int                 lanes;
    s = state_ff.s1;
    cond = '0;
    raised = '0;
    res = '0;
    c = '0;
    ea = '0;
    eb = '0;
    lanes = s.scalar ? 1 : 2;
    nxt_state = state_ff;

    nxt_state.s1 = ISSUE;
    nxt_state.rsel = (ISSUE.op == dpx_pkg::OP_F2I_TRUNC) ? dpx_pkg::RC_TRUNC : ROUND_FIELD;

    nxt_state.out_valid = s.valid;
    nxt_state.iflags_valid = 1'b0;
    nxt_state.gpr = '0;

    case (s.op)
      dpx_pkg::OP_ADD, dpx_pkg::OP_SUB, dpx_pkg::OP_MUL, dpx_pkg::OP_DIV, dpx_pkg::OP_SQRT,
      dpx_pkg::OP_WIDEN: begin
        cond = ARITH_COND;
        res = s.scalar ? {s.a[2*dpx_pkg::DW-1:dpx_pkg::DW], ARITH_RESULT[dpx_pkg::DW-1:0]}
                       : ARITH_RESULT;
      end
      dpx_pkg::OP_NARROW: begin
        cond = ARITH_COND;
        res = s.scalar ? {s.a[2*dpx_pkg::DW-1:dpx_pkg::SW], ARITH_RESULT[dpx_pkg::SW-1:0]}
                       : {64'h0, ARITH_RESULT[dpx_pkg::DW-1:0]};
      end
      dpx_pkg::OP_I2S, dpx_pkg::OP_I2D: begin
        cond = ARITH_COND;
        res = ARITH_RESULT;
      end
      dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC: begin
        cond = ARITH_COND;
        res = ARITH_RESULT;
        nxt_state.gpr = ARITH_RESULT[dpx_pkg::SW-1:0];
      end
      dpx_pkg::OP_CMP_PRED, dpx_pkg::OP_MAX, dpx_pkg::OP_MIN: begin
        res = s.a;
        for (int i = 0; i < 2; i++) begin
          if (i < lanes) begin
            ea = s.a[i*dpx_pkg::DW +: dpx_pkg::DW];
            eb = s.b[i*dpx_pkg::DW +: dpx_pkg::DW];
            c = fcmp(ea, eb);
            cond.den = cond.den | is_den(ea) | is_den(eb);
            if (s.op == dpx_pkg::OP_CMP_PRED) begin
              res[i*dpx_pkg::DW +: dpx_pkg::DW] = {dpx_pkg::DW{pred(c, s.imm[2:0])}};
              cond.inv = cond.inv | is_snan(ea) | is_snan(eb) |
                         (c[2] && (s.imm[1:0] != 2'h0) && (s.imm[1:0] != 2'h3));
            end else begin
              // Unordered or equal zeros return the second operand.
              if (s.op == dpx_pkg::OP_MAX) begin
                res[i*dpx_pkg::DW +: dpx_pkg::DW] = (!c[2] && !c[1] && !c[0]) ? ea : eb;
              end else begin
                res[i*dpx_pkg::DW +: dpx_pkg::DW] = (!c[2] && c[1]) ? ea : eb;
              end
              cond.inv = cond.inv | c[2];
            end
          end
        end
      end
      dpx_pkg::OP_CMP_ORD, dpx_pkg::OP_CMP_UNORD: begin
        ea = s.a[dpx_pkg::DW-1:0];
        eb = s.b[dpx_pkg::DW-1:0];
        c = fcmp(ea, eb);
        res = s.a;
        cond.den = is_den(ea) | is_den(eb);
        cond.inv = (s.op == dpx_pkg::OP_CMP_ORD) ? c[2] : (is_snan(ea) | is_snan(eb));
        nxt_state.iflags_valid = s.valid;
        nxt_state.iflags = c[2] ? dpx_pkg::IF_UNORD : c[1] ? dpx_pkg::IF_LT :
                           c[0] ? dpx_pkg::IF_EQ : dpx_pkg::IF_GT;
      end
      dpx_pkg::OP_AND:  res = s.a & s.b;
      dpx_pkg::OP_ANDN: res = ~s.a & s.b;
      dpx_pkg::OP_OR:   res = s.a | s.b;
      dpx_pkg::OP_XOR:  res = s.a ^ s.b;
      dpx_pkg::OP_MOV128: res = s.b;
      dpx_pkg::OP_MOV_HI: begin
        res = s.mem ? {64'h0, s.a[2*dpx_pkg::DW-1:dpx_pkg::DW]}
                    : {s.b[dpx_pkg::DW-1:0], s.a[dpx_pkg::DW-1:0]};
      end
      dpx_pkg::OP_MOV_LO: begin
        res = s.mem ? {64'h0, s.a[dpx_pkg::DW-1:0]}
                    : {s.a[2*dpx_pkg::DW-1:dpx_pkg::DW], s.b[dpx_pkg::DW-1:0]};
      end
      dpx_pkg::OP_MOV_SD: begin
        res = s.mem ? {64'h0, s.b[dpx_pkg::DW-1:0]}
                    : {s.a[2*dpx_pkg::DW-1:dpx_pkg::DW], s.b[dpx_pkg::DW-1:0]};
      end
      dpx_pkg::OP_SIGN_MASK: begin
        res = s.a;
        nxt_state.gpr = {30'h0, s.b[2*dpx_pkg::DW-1], s.b[dpx_pkg::DW-1]};
      end
      dpx_pkg::OP_UNPACK_HI: res = {s.b[2*dpx_pkg::DW-1:dpx_pkg::DW], s.a[2*dpx_pkg::DW-1:dpx_pkg::DW]};
      dpx_pkg::OP_UNPACK_LO: res = {s.b[dpx_pkg::DW-1:0], s.a[dpx_pkg::DW-1:0]};
      dpx_pkg::OP_SHUFFLE: begin
        res = {s.b[s.imm[1]*dpx_pkg::DW +: dpx_pkg::DW], s.a[s.imm[0]*dpx_pkg::DW +: dpx_pkg::DW]};
      end
      default: res = s.a;
    endcase

    // The class map is the final gate, so a stray datapath condition never escapes.
    raised = s.valid ? (cond & allowed(s.op)) : '0;
    // Side results hold, like the main result, until a valid operation replaces them.
    if (!s.valid) begin
      nxt_state.gpr = state_ff.gpr;
      nxt_state.iflags = state_ff.iflags;
    end
    if (s.valid) begin
      nxt_state.result = res;
    end
    // A condition arriving with the clear still lands in the sticky flags.
    nxt_state.sticky = (STICKY_CLEAR ? '0 : state_ff.sticky) | raised;
    nxt_state.exc = |(raised & ~EXC_MASK);
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_ff <= '0;
    end else if (CLK_EN) begin
      state_ff <= nxt_state;
    end
  end

  assign STAGE           = state_ff.s1;
  assign ROUND_SEL       = state_ff.rsel;
  assign RESULT_VALID    = state_ff.out_valid;
  assign RESULT          = state_ff.result;
  assign GPR_RESULT      = state_ff.gpr;
  assign INT_FLAGS       = state_ff.iflags;
  assign INT_FLAGS_VALID = state_ff.iflags_valid;
  assign STICKY_FLAGS    = state_ff.sticky;
  assign EXC_SIGNAL      = state_ff.exc;

endmodule
`default_nettype wire

// File: dpx_exception_unit_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dpx_exception_unit_checker (
  // Clock and controls.
  input wire logic                CORE_CLK,
  input wire logic                RESET,
  input wire logic                CLK_EN,
  input wire logic                STICKY_CLEAR,
  input wire logic [1:0]          ROUND_FIELD,
  input wire dpx_pkg::fp_flags_t  EXC_MASK,
  input wire dpx_pkg::fp_flags_t  ARITH_COND,
  input wire dpx_pkg::issue_t     ISSUE,
  // Outputs watched.
  input wire dpx_pkg::issue_t     STAGE,
  input wire logic [1:0]          ROUND_SEL,
  input wire logic                RESULT_VALID,
  input wire dpx_pkg::fp_flags_t  STICKY_FLAGS,
  input wire logic                EXC_SIGNAL
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_latency;
    CLK_EN && ISSUE.valid ##1 CLK_EN |=> RESULT_VALID;
  endproperty
  a_latency: assert property (p_latency) else $error("result pulse missing");
  property p_trunc;
    CLK_EN && ISSUE.valid && ISSUE.op == dpx_pkg::OP_F2I_TRUNC |=> ROUND_SEL == dpx_pkg::RC_TRUNC;
  endproperty
  a_trunc: assert property (p_trunc) else $error("truncate mode not selected");
  property p_round;
    CLK_EN && ISSUE.valid && ISSUE.op == dpx_pkg::OP_F2I_ROUND |=> ROUND_SEL == $past(ROUND_FIELD);
  endproperty
  a_round: assert property (p_round) else $error("rounding field not used");
  property p_zdiv;
    CLK_EN && STAGE.valid && STAGE.op != dpx_pkg::OP_DIV |=>
      STICKY_FLAGS.zdiv == (!$past(STICKY_CLEAR) && $past(STICKY_FLAGS.zdiv));
  endproperty
  a_zdiv: assert property (p_zdiv) else $error("divide-by-zero from non-divide");
  property p_none;
    CLK_EN && STAGE.valid && STAGE.op inside {[dpx_pkg::OP_AND:dpx_pkg::OP_SHUFFLE], dpx_pkg::OP_I2D} |=>
      !EXC_SIGNAL && STICKY_FLAGS == ($past(STICKY_CLEAR) ? 6'h00 : $past(STICKY_FLAGS));
  endproperty
  a_none: assert property (p_none) else $error("flag from flagless op");
  property p_cmp;
    CLK_EN && STAGE.valid && STAGE.op inside {[dpx_pkg::OP_CMP_PRED:dpx_pkg::OP_MIN], dpx_pkg::OP_WIDEN} |=>
      STICKY_FLAGS[3:0] == ($past(STICKY_CLEAR) ? 4'h0 : $past(STICKY_FLAGS[3:0]));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare class raised extra flag");
  property p_sqrt;
    CLK_EN && STAGE.valid && STAGE.op == dpx_pkg::OP_SQRT |=>
      STICKY_FLAGS[3:1] == ($past(STICKY_CLEAR) ? 3'h0 : $past(STICKY_FLAGS[3:1]));
  endproperty
  a_sqrt: assert property (p_sqrt) else $error("square root raised extra flag");
  property p_exc;
    CLK_EN && STAGE.valid && STAGE.op == dpx_pkg::OP_DIV && |(ARITH_COND & ~EXC_MASK) |=> EXC_SIGNAL;
  endproperty
  a_exc: assert property (p_exc) else $error("unmasked condition not signalled");
endmodule
bind dpx_exception_unit dpx_exception_unit_checker u_chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .CLK_EN(CLK_EN),
  .STICKY_CLEAR(STICKY_CLEAR), .ROUND_FIELD(ROUND_FIELD), .EXC_MASK(EXC_MASK), .ARITH_COND(ARITH_COND),
  .ISSUE(ISSUE), .STAGE(STAGE), .ROUND_SEL(ROUND_SEL), .RESULT_VALID(RESULT_VALID),
  .STICKY_FLAGS(STICKY_FLAGS), .EXC_SIGNAL(EXC_SIGNAL));
`default_nettype wire

// File: dpx_pkg.sv
// What this block does
// - Add and subtract may raise all conditions except divide-by-zero.
// - Scalar arithmetic touches only the low element; packed touches both.
// - Multiply may raise all conditions except divide-by-zero.
// - Divide may raise all six conditions; only divide raises divide-by-zero.
// - Predicate compares raise only invalid and denormal.
// - Ordered/unordered scalar compares set integer flags; raise only invalid, denormal.
// - Maximum and minimum return larger/smaller elements; raise only invalid, denormal.
// - Square root raises only invalid, denormal and inexact.
// - Four integers to four singles raises only inexact.
// - Every float to integer conversion raises only invalid and inexact.
// - Rounding conversions use the rounding field of the control/status register.
// - Truncating conversions always truncate, whatever the rounding field holds.
// - Double to single narrowing raises all conditions except divide-by-zero.
// - Single to double widening raises only invalid and denormal.
// - Integer to double conversion raises no condition, from any source.
// - Bitwise AND, AND-NOT, OR and XOR raise no condition.
// - Aligned and unaligned 128-bit moves raise no condition.
// - Half moves carry 64 bits to one field, keep the other in register form, zero it in memory form, raise nothing.
// - Scalar double move carries 64 bits and raises nothing.
// - Sign-mask extraction copies element signs into a 32-bit register, raises nothing.
// - Interleaves merge high or low halves; interleaves and shuffle raise nothing.
package dpx_pkg;

  typedef enum logic [4:0] {
    OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_SQRT, OP_CMP_PRED, OP_CMP_ORD, OP_CMP_UNORD,
    OP_MAX, OP_MIN, OP_I2S, OP_F2I_ROUND, OP_F2I_TRUNC, OP_NARROW, OP_WIDEN, OP_I2D,
    OP_AND, OP_ANDN, OP_OR, OP_XOR, OP_MOV128, OP_MOV_HI, OP_MOV_LO, OP_MOV_SD,
    OP_SIGN_MASK, OP_UNPACK_HI, OP_UNPACK_LO, OP_SHUFFLE
  } op_t;

  typedef struct packed {
    logic inv;
    logic den;
    logic zdiv;
    logic ovf;
    logic unf;
    logic inx;
  } fp_flags_t;

  typedef struct packed {
    logic zf;
    logic pf;
    logic cf;
  } int_flags_t;

  typedef struct packed {
    logic         valid;
    op_t          op;
    logic         scalar;
    logic         mem;
    logic [7:0]   imm;
    logic [127:0] a;
    logic [127:0] b;
  } issue_t;

  localparam int DW = 64;
  localparam int SW = 32;
  localparam int EXP_LO = 52;
  localparam int EXP_HI = 62;
  localparam int QUIET_BIT = 51;
  localparam logic [10:0] EXP_ONES = 11'h7ff;
  localparam logic [1:0] RC_TRUNC = 2'h3;

  localparam fp_flags_t MAP_ARITH  = 6'h37;
  localparam fp_flags_t MAP_DIV    = 6'h3f;
  localparam fp_flags_t MAP_CMP    = 6'h30;
  localparam fp_flags_t MAP_SQRT   = 6'h31;
  localparam fp_flags_t MAP_I2S    = 6'h01;
  localparam fp_flags_t MAP_F2I    = 6'h21;
  localparam fp_flags_t MAP_NONE   = 6'h00;

  localparam int_flags_t IF_UNORD = 3'h7;
  localparam int_flags_t IF_GT    = 3'h0;
  localparam int_flags_t IF_LT    = 3'h1;
  localparam int_flags_t IF_EQ    = 3'h4;

  localparam logic [2:0] PR_EQ    = 3'h0;
  localparam logic [2:0] PR_LT    = 3'h1;
  localparam logic [2:0] PR_LE    = 3'h2;
  localparam logic [2:0] PR_UNORD = 3'h3;
  localparam logic [2:0] PR_NEQ   = 3'h4;
  localparam logic [2:0] PR_NLT   = 3'h5;
  localparam logic [2:0] PR_NLE   = 3'h6;

endpackage

// File: test_dpx_exception_unit.sv
`timescale 1ns/1ps
`default_nettype none
module test_dpx_exception_unit;
  logic                clk = 1'h0;
  logic                rst = 1'h1;
  logic                en = 1'h0;
  logic                clr = 1'h0;
  logic [1:0]          rf = 2'h0;
  logic [1:0]          rsel;
  logic [127:0]        ar = 128'h0;
  logic [127:0]        res;
  logic [31:0]         gpr;
  logic                rv;
  logic                ifv;
  logic                exc;
  dpx_pkg::issue_t     iss = '0;
  dpx_pkg::issue_t     st = '0;
  dpx_pkg::issue_t     stg;
  dpx_pkg::fp_flags_t  ac = '0;
  dpx_pkg::fp_flags_t  msk = '0;
  dpx_pkg::fp_flags_t  stk;
  dpx_pkg::fp_flags_t  stk_e = '0;
  dpx_pkg::int_flags_t ifl;
  dpx_pkg::int_flags_t ifl_e = '0;
  logic [127:0]        res_e = '0;
  logic [31:0]         gpr_e = 32'h0;
  int                  err_count = 0;
  int                  comparisons = 0;
  int                  cyc = 0;
  dpx_exception_unit DUT (.CORE_CLK(clk), .RESET(rst), .CLK_EN(en), .ISSUE(iss), .ROUND_FIELD(rf), .EXC_MASK(msk),
    .STICKY_CLEAR(clr), .STAGE(stg), .ROUND_SEL(rsel), .ARITH_RESULT(ar), .ARITH_COND(ac), .RESULT_VALID(rv),
    .RESULT(res), .GPR_RESULT(gpr), .INT_FLAGS(ifl), .INT_FLAGS_VALID(ifv), .STICKY_FLAGS(stk), .EXC_SIGNAL(exc));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      summarize();
    end
  end
  task summarize();
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [127:0] g, input logic [127:0] x);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  endtask
  function automatic dpx_pkg::fp_flags_t cmap(dpx_pkg::op_t o);
    case (o)
      dpx_pkg::OP_ADD, dpx_pkg::OP_SUB, dpx_pkg::OP_MUL, dpx_pkg::OP_NARROW: return 6'h37;
      dpx_pkg::OP_DIV: return 6'h3f;
      dpx_pkg::OP_SQRT: return 6'h31;
      dpx_pkg::OP_WIDEN: return 6'h30;
      dpx_pkg::OP_I2S: return 6'h01;
      dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC: return 6'h21;
      default: return 6'h00;
    endcase
  endfunction
  function automatic logic [128:0] expect_res(dpx_pkg::issue_t s, logic [127:0] r);
    logic [63:0] a1, a0, b1, b0;
    {a1, a0} = s.a;
    {b1, b0} = s.b;
    case (s.op)
      dpx_pkg::OP_ADD, dpx_pkg::OP_SUB, dpx_pkg::OP_MUL, dpx_pkg::OP_DIV, dpx_pkg::OP_SQRT, dpx_pkg::OP_WIDEN:
        return {1'h1, s.scalar ? {a1, r[63:0]} : r};
      dpx_pkg::OP_CMP_PRED:
        return {1'h1, s.scalar ? a1 : pr(a1, b1, s.imm[2:0]), pr(a0, b0, s.imm[2:0])};
      dpx_pkg::OP_CMP_ORD, dpx_pkg::OP_CMP_UNORD, dpx_pkg::OP_SIGN_MASK: return {1'h1, s.a};
      dpx_pkg::OP_MOV128: return {1'h1, s.b};
      dpx_pkg::OP_I2S, dpx_pkg::OP_I2D, dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC: return {1'h1, r};
      dpx_pkg::OP_NARROW: return {1'h1, s.scalar ? {s.a[127:32], r[31:0]} : {64'h0, r[63:0]}};
      dpx_pkg::OP_MAX: return {1'h1, s.scalar ? a1 : (a1 > b1 ? a1 : b1), a0 > b0 ? a0 : b0};
      dpx_pkg::OP_MIN: return {1'h1, s.scalar ? a1 : (a1 < b1 ? a1 : b1), a0 < b0 ? a0 : b0};
      dpx_pkg::OP_AND: return {1'h1, s.a & s.b};
      dpx_pkg::OP_ANDN: return {1'h1, ~s.a & s.b};
      dpx_pkg::OP_OR: return {1'h1, s.a | s.b};
      dpx_pkg::OP_XOR: return {1'h1, s.a ^ s.b};
      dpx_pkg::OP_MOV_HI: return {1'h1, s.mem ? {64'h0, a1} : {b0, a0}};
      dpx_pkg::OP_MOV_LO: return {1'h1, s.mem ? {64'h0, a0} : {a1, b0}};
      dpx_pkg::OP_MOV_SD: return {1'h1, s.mem ? {64'h0, b0} : {a1, b0}};
      dpx_pkg::OP_UNPACK_HI: return {1'h1, b1, a1};
      dpx_pkg::OP_UNPACK_LO: return {1'h1, b0, a0};
      dpx_pkg::OP_SHUFFLE: return {1'h1, s.imm[1] ? b1 : b0, s.imm[0] ? a1 : a0};
      default: return '0;
    endcase
  endfunction
  // Predicate result of one lane for ordered, non-negative operands.
  function automatic logic [63:0] pr(logic [63:0] x, logic [63:0] y, logic [2:0] p);
    logic lt;
    logic eq;
    logic r;
    lt = x < y;
    eq = x == y;
    case (p)
      3'h0: r = eq;
      3'h1: r = lt;
      3'h2: r = lt | eq;
      3'h3: r = 1'h0;
      3'h4: r = !eq;
      3'h5: r = !lt;
      3'h6: r = !(lt | eq);
      default: r = 1'h1;
    endcase
    return {64{r}};
  endfunction
  function automatic logic dn(logic [63:0] v);
    return v[62:52] == 11'h000 && v[51:0] != 52'h0;
  endfunction
  // Compares, minimum and maximum flag denormal inputs themselves: lane 0 always, lane 1 when packed, except ordered/unordered compares.
  function automatic dpx_pkg::fp_flags_t cfl(dpx_pkg::issue_t s);
    dpx_pkg::fp_flags_t f;
    f = '0;
    if (s.op inside {[dpx_pkg::OP_CMP_PRED:dpx_pkg::OP_MIN]})
      f.den = dn(s.a[63:0]) | dn(s.b[63:0]) |
              (!s.scalar && s.op inside {dpx_pkg::OP_CMP_PRED, dpx_pkg::OP_MAX, dpx_pkg::OP_MIN} &&
               (dn(s.a[127:64]) | dn(s.b[127:64])));
    return f;
  endfunction
  // Non-negative doubles keep compares ordered; zeros and denormals each come one time in eight.
  function automatic logic [63:0] pn();
    logic [2:0] k;
    k = 3'($urandom);
    if (k == 3'h0) return 64'h0;
    if (k == 3'h1) return {12'h000, 20'($urandom), $urandom | 32'h1};
    return {1'h0, 11'h001 + 11'($urandom % 32'h7fe), 20'($urandom), $urandom};
  endfunction
  function automatic dpx_pkg::issue_t mk(int o, logic v);
    logic [127:0] a;
    a = {pn(), pn()};
    return '{v, dpx_pkg::op_t'(o), 1'($urandom), 1'($urandom), 8'($urandom), a,
             ($urandom % 32'h4 == 32'h0) ? a : {pn(), pn()}};
  endfunction
  task step(input dpx_pkg::issue_t ni, input logic ne, input logic full);
    logic [128:0]       e;
    dpx_pkg::fp_flags_t set;
    logic               cmpf;
    @(negedge clk);
    if (en) begin
      set = st.valid ? (ac & cmap(st.op)) | cfl(st) : 6'h00;
      e = st.valid ? expect_res(st, ar) : '0;
      cmpf = st.valid && st.op inside {dpx_pkg::OP_CMP_ORD, dpx_pkg::OP_CMP_UNORD};
      stk_e = (clr ? 6'h00 : stk_e) | set;
      chk(rv, st.valid);
      if (e[128]) res_e = e[127:0];
      chk(res, res_e);
      if (st.valid) gpr_e = st.op inside {dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC} ? ar[31:0] :
        st.op == dpx_pkg::OP_SIGN_MASK ? {30'h0, st.b[127], st.b[63]} : 32'h0;
      chk(gpr, gpr_e);
      chk(ifv, cmpf);
      if (cmpf) ifl_e = st.a[63:0] == st.b[63:0] ? 3'h4 : st.a[63:0] < st.b[63:0] ? 3'h1 : 3'h0;
      chk(ifl, ifl_e);
      chk(stk, stk_e);
      chk(exc, |(set & ~msk));
      if (iss.valid && iss.op inside {dpx_pkg::OP_F2I_ROUND, dpx_pkg::OP_F2I_TRUNC})
        chk(rsel, iss.op == dpx_pkg::OP_F2I_TRUNC ? 2'h3 : rf);
      chk(stg.valid, iss.valid);
      st = iss;
    end
    iss = ni;
    en = ne;
    ar = {$urandom, $urandom, $urandom, $urandom};
    ac = full ? 6'h3f : 6'($urandom);
    msk = 6'($urandom);
    clr = ($urandom % 32'h10) == 32'h0;
    rf = 2'($urandom);
  endtask
  initial begin
    void'($urandom(32'h4ca7193d));
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    en = 1'h1;
    for (int o = 0; o < 32'h1c; o++) step(mk(o, 1'h1), 1'h1, 1'h1);
    repeat (32'hbb8) step(mk($urandom % 32'h1c, ($urandom % 32'h4) != 32'h0), ($urandom % 32'h8) != 32'h0, 1'h0);
    repeat (3) step('0, 1'h1, 1'h0);
    summarize();
  end
endmodule
`default_nettype wire
